// ==== core/gac_pkg.sv ====
// constants, field layout and operation codes for the general alu datapath
// Functional notes
// - absolute value negates a negative first source, else passes it.
// - set-if-less-or-equal writes 1 or 0; signed and unsigned variants.
// - minimum returns first source if strictly smaller, else second.
// - maximum returns second source if first strictly smaller, else first.
// - extend low 16 or 8 bits to 32, sign or zero variants.
// - signed immediate clip saturates to -2^(imm-1)..2^(imm-1)-1 range, else passes.
// - signed immediate clip with zero immediate uses bounds -1 and 0.
// - unsigned immediate clip floors at zero; upper bound zero if imm zero.
// - signed register clip bounds between -(second+1) and second.
// - immediate add sums sources, shifts right arithmetic or logical.
// - immediate subtract takes first minus second, then shifts right.
// - rounded immediate add adds 2^(imm-1) to the sum before shifting.
// - rounded immediate subtract adds 2^(imm-1) to difference first.
// - zero immediate shift makes the rounding addend zero.
// - register add accumulates first source into destination, then shifts.
// - register subtract takes destination minus first source, then shifts.
// - rounded register add adds 2^(shift-1) before shifting.
// - rounded register subtract adds rounding constant before shifting.
// - zero register shift amount makes the rounding addend zero.
// - register forms: opcode 0101011, funct3 011, funct7 selects op.
// - immediate shift forms: opcode 1011011, funct3 010 add, 011 sub.
package gac_pkg;

  // ---------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------
  localparam int OPC_LSB = 0;
  localparam int RD_LSB = 7;
  localparam int F3_LSB = 12;
  localparam int RS1_LSB = 15;
  localparam int RS2_LSB = 20;
  localparam int F7_LSB = 25;
  localparam int IS3_LSB = 25;
  localparam int F2_RND_POS = 31;
  localparam int F2_UNS_POS = 30;
  localparam int ACC_SUB_POS = 2;
  localparam int ACC_RND_POS = 1;
  localparam int ACC_UNS_POS = 0;

  // ---------------------------------------------------------------
  // major opcodes, funct3 and funct7 codes
  // ---------------------------------------------------------------
  localparam logic [6:0] OPC_REG = 7'h2B;
  localparam logic [6:0] OPC_IMM = 7'h5B;
  localparam logic [2:0] F3_REG = 3'h3;
  localparam logic [2:0] F3_ADD = 3'h2;
  localparam logic [2:0] F3_SUB = 3'h3;
  localparam logic [6:0] F7_ABSV = 7'h28;
  localparam logic [6:0] F7_SLE_S = 7'h29;
  localparam logic [6:0] F7_SLE_U = 7'h2A;
  localparam logic [6:0] F7_MIN_S = 7'h2B;
  localparam logic [6:0] F7_MIN_U = 7'h2C;
  localparam logic [6:0] F7_MAX_S = 7'h2D;
  localparam logic [6:0] F7_MAX_U = 7'h2E;
  localparam logic [6:0] F7_SEXT_H = 7'h30;
  localparam logic [6:0] F7_ZEXT_H = 7'h31;
  localparam logic [6:0] F7_SEXT_B = 7'h32;
  localparam logic [6:0] F7_ZEXT_B = 7'h33;
  localparam logic [6:0] F7_SAT_SI = 7'h38;
  localparam logic [6:0] F7_SAT_UI = 7'h39;
  localparam logic [6:0] F7_SAT_SR = 7'h3A;
  localparam logic [6:0] F7_SAT_UR = 7'h3B;
  localparam logic [3:0] F7_ACC_TOP = 4'h8;
  localparam logic [4:0] RS2_NONE = 5'h00;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [4:0] RD_RST = 5'h00;

  typedef enum logic [4:0] {
    OP_NONE, OP_ABSV, OP_SLE_S, OP_SLE_U, OP_MIN_S, OP_MIN_U,
    OP_MAX_S, OP_MAX_U, OP_SEXT_H, OP_ZEXT_H, OP_SEXT_B, OP_ZEXT_B,
    OP_SAT_SI, OP_SAT_UI, OP_SAT_SR, OP_SAT_UR, OP_NORM
  } gac_op_t;

endpackage

// ==== core/gac_dec_if.sv ====
// decoded operation fields passed from the decoder to the datapath
`timescale 1ns/1ps
interface gac_dec_if;
  gac_pkg::gac_op_t op;
  logic hit;
  logic rs2_bad;
  logic norm_sub;
  logic norm_rnd;
  logic norm_uns;
  logic norm_acc;
  logic [4:0] shamt_imm;
  logic [4:0] clip_imm;
  logic [4:0] rd;

  modport dec (
    output op, hit, rs2_bad, norm_sub, norm_rnd, norm_uns, norm_acc,
    output shamt_imm, clip_imm, rd
  );
  modport exe (
    input op, hit, rs2_bad, norm_sub, norm_rnd, norm_uns, norm_acc,
    input shamt_imm, clip_imm, rd
  );
endinterface

// ==== core/gac_decode.sv ====
// instruction decoder for the general alu operations
`timescale 1ns/1ps
module gac_decode (
  input wire logic [31:0] instr_i,
  gac_dec_if.dec dec
);
  logic [6:0] opc;
  logic [2:0] f3;
  logic [6:0] f7;
  logic [4:0] rs2;
  logic single;

  assign opc = instr_i[gac_pkg::OPC_LSB +: 7];
  assign f3 = instr_i[gac_pkg::F3_LSB +: 3];
  assign f7 = instr_i[gac_pkg::F7_LSB +: 7];
  assign rs2 = instr_i[gac_pkg::RS2_LSB +: 5];
  assign dec.rd = instr_i[gac_pkg::RD_LSB +: 5];
  assign dec.clip_imm = rs2;
  assign dec.shamt_imm = instr_i[gac_pkg::IS3_LSB +: 5];
  assign dec.hit = (dec.op != gac_pkg::OP_NONE);
  assign dec.rs2_bad = single && (rs2 != gac_pkg::RS2_NONE);

  always_comb begin
    dec.op = gac_pkg::OP_NONE;
    dec.norm_sub = 1'b0;
    dec.norm_rnd = 1'b0;
    dec.norm_uns = 1'b0;
    dec.norm_acc = 1'b0;
    single = 1'b0;
    if (opc == gac_pkg::OPC_REG && f3 == gac_pkg::F3_REG) begin
      unique case (f7)
        gac_pkg::F7_ABSV: begin
          dec.op = gac_pkg::OP_ABSV;
          single = 1'b1;
        end
        gac_pkg::F7_SLE_S: dec.op = gac_pkg::OP_SLE_S;
        gac_pkg::F7_SLE_U: dec.op = gac_pkg::OP_SLE_U;
        gac_pkg::F7_MIN_S: dec.op = gac_pkg::OP_MIN_S;
        gac_pkg::F7_MIN_U: dec.op = gac_pkg::OP_MIN_U;
        gac_pkg::F7_MAX_S: dec.op = gac_pkg::OP_MAX_S;
        gac_pkg::F7_MAX_U: dec.op = gac_pkg::OP_MAX_U;
        gac_pkg::F7_SEXT_H: begin
          dec.op = gac_pkg::OP_SEXT_H;
          single = 1'b1;
        end
        gac_pkg::F7_ZEXT_H: begin
          dec.op = gac_pkg::OP_ZEXT_H;
          single = 1'b1;
        end
        gac_pkg::F7_SEXT_B: begin
          dec.op = gac_pkg::OP_SEXT_B;
          single = 1'b1;
        end
        gac_pkg::F7_ZEXT_B: begin
          dec.op = gac_pkg::OP_ZEXT_B;
          single = 1'b1;
        end
        gac_pkg::F7_SAT_SI: dec.op = gac_pkg::OP_SAT_SI;
        gac_pkg::F7_SAT_UI: dec.op = gac_pkg::OP_SAT_UI;
        gac_pkg::F7_SAT_SR: dec.op = gac_pkg::OP_SAT_SR;
        gac_pkg::F7_SAT_UR: dec.op = gac_pkg::OP_SAT_UR;
        default: begin
          // low three funct7 bits pick sub, round and unsigned
          if (f7[6:3] == gac_pkg::F7_ACC_TOP) begin
            dec.op = gac_pkg::OP_NORM;
            dec.norm_acc = 1'b1;
            dec.norm_sub = f7[gac_pkg::ACC_SUB_POS];
            dec.norm_rnd = f7[gac_pkg::ACC_RND_POS];
            dec.norm_uns = f7[gac_pkg::ACC_UNS_POS];
          end
        end
      endcase
    end else if (opc == gac_pkg::OPC_IMM &&
                 (f3 == gac_pkg::F3_ADD || f3 == gac_pkg::F3_SUB)) begin
      dec.op = gac_pkg::OP_NORM;
      dec.norm_sub = (f3 == gac_pkg::F3_SUB);
      dec.norm_rnd = instr_i[gac_pkg::F2_RND_POS];
      dec.norm_uns = instr_i[gac_pkg::F2_UNS_POS];
    end
  end
endmodule

// ==== core/gac_norm_shift.sv ====
// add or subtract with rounding and normalising right shift
`timescale 1ns/1ps
module gac_norm_shift #(
  parameter int WIDTH = 32
) (
  gac_dec_if.exe ctl,
  input wire logic [WIDTH-1:0] src_a_i,
  input wire logic [WIDTH-1:0] src_b_i,
  input wire logic [WIDTH-1:0] src_d_i,
  output logic [WIDTH-1:0] norm_o
);
  initial begin
    if (WIDTH != 32) $error("gac_norm_shift serves 32-bit data only");
  end

  logic [WIDTH-1:0] base;
  logic [WIDTH-1:0] other;
  logic [WIDTH-1:0] sum;
  logic [WIDTH-1:0] addend;
  logic [WIDTH-1:0] pre;
  logic [4:0] amt;

  // accumulating forms use the destination as the left operand
  assign base = ctl.norm_acc ? src_d_i : src_a_i;
  assign other = ctl.norm_acc ? src_a_i : src_b_i;
  assign amt = ctl.norm_acc ? src_b_i[4:0] : ctl.shamt_imm;
  assign sum = ctl.norm_sub ? base - other : base + other;

  always_comb begin
    addend = '0;
    if (ctl.norm_rnd && amt != 5'h00) begin
      addend = WIDTH'(1) << (amt - 5'h01);
    end
  end

  assign pre = sum + addend;

  always_comb begin
    if (ctl.norm_uns) begin
      norm_o = pre >> amt;
    end else begin
      norm_o = WIDTH'($signed(pre) >>> amt);
    end
  end
endmodule

// ==== core/gac_alu.sv ====
// general alu datapath: compare, extend, clip and normalising add/sub
`timescale 1ns/1ps
module gac_alu #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [WIDTH-1:0] src_a_i,
  input wire logic [WIDTH-1:0] src_b_i,
  input wire logic [WIDTH-1:0] src_d_i,
  output logic wb_valid_o,
  output logic wb_we_o,
  output logic [4:0] wb_rd_o,
  output logic [WIDTH-1:0] wb_data_o,
  output logic illegal_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (WIDTH != 32) begin
      $error("gac_alu serves 32-bit data only");
    end
  end

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // strict less-than, signed or unsigned
  function automatic logic less_than(
    input logic [WIDTH-1:0] x,
    input logic [WIDTH-1:0] y,
    input logic uns
  );
    logic res;
    res = 1'b0;
    if (uns) begin
      res = (x < y);
    end else begin
      res = ($signed(x) < $signed(y));
    end
    return res;
  endfunction

  // widen the low bits of a value by sign or zero
  function automatic logic [WIDTH-1:0] widen(
    input logic [WIDTH-1:0] x,
    input logic half,
    input logic sgn
  );
    logic [WIDTH-1:0] res;
    res = '0;
    if (half) begin
      res = {{(WIDTH-16){sgn & x[15]}}, x[15:0]};
    end else begin
      res = {{(WIDTH-8){sgn & x[7]}}, x[7:0]};
    end
    return res;
  endfunction

  // saturate x into [lo, hi]; a value at a bound takes the bound
  function automatic logic [WIDTH-1:0] saturate(
    input logic [WIDTH-1:0] x,
    input logic [WIDTH-1:0] lo,
    input logic [WIDTH-1:0] hi
  );
    logic [WIDTH-1:0] res;
    res = x;
    if ($signed(x) <= $signed(lo)) begin
      res = lo;
    end else if ($signed(x) >= $signed(hi)) begin
      res = hi;
    end
    return res;
  endfunction

  // upper clip bound 2^(imm-1)-1, zero for a zero immediate
  function automatic logic [WIDTH-1:0] clip_high(
    input logic [4:0] imm
  );
    logic [WIDTH-1:0] res;
    res = '0;
    if (imm != 5'h00) begin
      res = (WIDTH'(1) << (imm - 5'h01)) - WIDTH'(1);
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // decode and normalising unit
  // ---------------------------------------------------------------
  gac_dec_if dec_bus ();

  gac_decode u_decode (
    .instr_i(instr_i),
    .dec(dec_bus)
  );

  logic [WIDTH-1:0] norm_res;

  gac_norm_shift #(
    .WIDTH(WIDTH)
  ) u_norm (
    .ctl(dec_bus),
    .src_a_i(src_a_i),
    .src_b_i(src_b_i),
    .src_d_i(src_d_i),
    .norm_o(norm_res)
  );

  // ---------------------------------------------------------------
  // comparisons
  // ---------------------------------------------------------------
  logic lt_s;
  logic lt_u;
  logic a_neg;
  logic a_le_zero;

  assign lt_s = less_than(src_a_i, src_b_i, 1'b0);
  assign lt_u = less_than(src_a_i, src_b_i, 1'b1);
  assign a_neg = src_a_i[WIDTH-1];
  assign a_le_zero = a_neg || (src_a_i == '0);

  // ---------------------------------------------------------------
  // clip bounds
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] imm_high;
  logic [WIDTH-1:0] imm_low;
  logic [WIDTH-1:0] reg_low;

  assign imm_high = clip_high(dec_bus.clip_imm);
  // -2^(imm-1) equals ~(2^(imm-1)-1); zero immediate gives -1
  assign imm_low = ~imm_high;
  // -(b+1) is the one's complement of b, no adder needed
  assign reg_low = ~src_b_i;

  // ---------------------------------------------------------------
  // result selection
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] next_result;

  always_comb begin
    next_result = '0;
    unique case (dec_bus.op)
      gac_pkg::OP_ABSV: begin
        next_result = a_neg ? WIDTH'(0) - src_a_i : src_a_i;
      end
      gac_pkg::OP_SLE_S: begin
        next_result = WIDTH'(!less_than(src_b_i, src_a_i, 1'b0));
      end
      gac_pkg::OP_SLE_U: begin
        next_result = WIDTH'(!less_than(src_b_i, src_a_i, 1'b1));
      end
      gac_pkg::OP_MIN_S: begin
        next_result = lt_s ? src_a_i : src_b_i;
      end
      gac_pkg::OP_MIN_U: begin
        next_result = lt_u ? src_a_i : src_b_i;
      end
      gac_pkg::OP_MAX_S: begin
        next_result = lt_s ? src_b_i : src_a_i;
      end
      gac_pkg::OP_MAX_U: begin
        next_result = lt_u ? src_b_i : src_a_i;
      end
      gac_pkg::OP_SEXT_H: begin
        next_result = widen(src_a_i, 1'b1, 1'b1);
      end
      gac_pkg::OP_ZEXT_H: begin
        next_result = widen(src_a_i, 1'b1, 1'b0);
      end
      gac_pkg::OP_SEXT_B: begin
        next_result = widen(src_a_i, 1'b0, 1'b1);
      end
      gac_pkg::OP_ZEXT_B: begin
        next_result = widen(src_a_i, 1'b0, 1'b0);
      end
      gac_pkg::OP_SAT_SI: begin
        next_result = saturate(src_a_i, imm_low, imm_high);
      end
      gac_pkg::OP_SAT_UI: begin
        // zero floor wins even when the upper bound is also zero
        next_result = saturate(src_a_i, '0, imm_high);
      end
      gac_pkg::OP_SAT_SR: begin
        next_result = saturate(src_a_i, reg_low, src_b_i);
      end
      gac_pkg::OP_SAT_UR: begin
        if (a_le_zero) begin
          next_result = '0;
        end else if (!lt_s) begin
          next_result = src_b_i;
        end else begin
          next_result = src_a_i;
        end
      end
      gac_pkg::OP_NORM: begin
        next_result = norm_res;
      end
      gac_pkg::OP_NONE: begin
        next_result = '0;
      end
      default: begin
        next_result = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // issue qualification
  // ---------------------------------------------------------------
  logic accept;
  logic reject;

  // single-source forms with a non-zero second source field refused
  assign accept = issue_valid_i && dec_bus.hit && !dec_bus.rs2_bad;
  assign reject = issue_valid_i && dec_bus.hit && dec_bus.rs2_bad;

  // ---------------------------------------------------------------
  // writeback registers
  // ---------------------------------------------------------------
  // one result per accepted issue, never a stall
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wb_valid_o <= 1'b0;
    end else begin
      wb_valid_o <= accept;
    end
  end

  // register zero is never written
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wb_we_o <= 1'b0;
    end else begin
      wb_we_o <= accept && (dec_bus.rd != 5'h00);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wb_rd_o <= gac_pkg::RD_RST;
    end else if (accept) begin
      wb_rd_o <= dec_bus.rd;
    end
  end

  // data holds its last value between issues
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wb_data_o <= gac_pkg::RESULT_RST;
    end else if (accept) begin
      wb_data_o <= next_result;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= reject;
    end
  end

endmodule

// ==== verif/gac_alu_props.sv ====
// concurrent checks on the general alu datapath ports
`timescale 1ns/1ps
module gac_alu_props #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [WIDTH-1:0] src_a_i,
  input wire logic [WIDTH-1:0] src_b_i,
  input wire logic [WIDTH-1:0] src_d_i,
  input wire logic wb_valid_o,
  input wire logic wb_we_o,
  input wire logic [4:0] wb_rd_o,
  input wire logic [WIDTH-1:0] wb_data_o,
  input wire logic illegal_o
);
  logic [6:0] f7;
  logic is_reg, rs2z, single, known, rec;
  assign f7 = instr_i[31:25];
  assign rs2z = instr_i[24:20] == 5'h00;
  assign is_reg = issue_valid_i && instr_i[6:0] == gac_pkg::OPC_REG
    && instr_i[14:12] == gac_pkg::F3_REG;
  assign single = f7 == gac_pkg::F7_ABSV || f7[6:2] == 5'h0C;
  assign known = (f7 >= 7'h28 && f7 <= 7'h2E) || f7[6:2] == 5'h0C
    || (f7 >= 7'h38 && f7 <= 7'h3B) || f7[6:3] == 4'h8;
  // funct3 2 and 3 of the immediate group share bits 14:13
  assign rec = (is_reg && known && !(single && !rs2z)) || (issue_valid_i
    && instr_i[6:0] == gac_pkg::OPC_IMM && instr_i[14:13] == 2'h1);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_op(logic [6:0] v, logic need_z);
    is_reg && f7 == v && (!need_z || rs2z);
  endsequence
  sequence s_answer;
    ##1 wb_valid_o && !illegal_o;
  endsequence

  a_wb_next_cycle: assert property (rec |-> s_answer)
    else $error("no writeback one cycle after accepted issue");
  a_wb_has_cause: assert property (wb_valid_o |-> $past(rec))
    else $error("writeback without an accepted issue");
  a_we_gate: assert property (
    wb_we_o == (wb_valid_o && wb_rd_o != 5'h00))
    else $error("write enable does not follow valid and rd");
  a_rd_capture: assert property (
    rec |=> wb_rd_o == $past(instr_i[11:7]))
    else $error("destination index not captured");
  a_abs_result: assert property (
    s_op(gac_pkg::F7_ABSV, 1'b1) |=> wb_data_o == ($past(src_a_i[WIDTH-1])
    ? -$past(src_a_i) : $past(src_a_i)))
    else $error("absolute value wrong");
  a_sle_signed: assert property (
    s_op(gac_pkg::F7_SLE_S, 1'b0) |=>
    wb_data_o == WIDTH'($signed($past(src_a_i)) <= $signed($past(src_b_i))))
    else $error("signed set-le wrong");
  a_min_unsigned: assert property (
    s_op(gac_pkg::F7_MIN_U, 1'b0) |=>
    wb_data_o == ($past(src_a_i) < $past(src_b_i) ? $past(src_a_i)
    : $past(src_b_i))) else $error("unsigned minimum wrong");
  a_half_sext: assert property (
    s_op(gac_pkg::F7_SEXT_H, 1'b1) |=>
    wb_data_o == {{16{$past(src_a_i[15])}}, $past(src_a_i[15:0])})
    else $error("half sign extend wrong");
  a_single_refused: assert property (
    is_reg && single && !rs2z |=> illegal_o && !wb_valid_o)
    else $error("bad rs2 field not refused");
  // both sides signed, else the compare turns the shift logical
  a_acc_add: assert property (
    s_op(7'h40, 1'b0) |=> $signed(wb_data_o) ==
    ($signed($past(src_d_i) + $past(src_a_i)) >>> $past(src_b_i[4:0])))
    else $error("accumulating add wrong");
endmodule

bind gac_alu gac_alu_props #(.WIDTH(WIDTH)) u_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i),
  .instr_i(instr_i), .src_a_i(src_a_i), .src_b_i(src_b_i),
  .src_d_i(src_d_i), .wb_valid_o(wb_valid_o), .wb_we_o(wb_we_o),
  .wb_rd_o(wb_rd_o), .wb_data_o(wb_data_o), .illegal_o(illegal_o)
);

// ==== verif/gac_core_model.sv ====
// issue model that drives instruction and operand values to the datapath
`timescale 1ns/1ps
module gac_core_model (
  input wire logic clk_i,
  output logic issue_valid_o,
  output logic [31:0] instr_o,
  output logic [31:0] src_a_o,
  output logic [31:0] src_b_o,
  output logic [31:0] src_d_o
);
  initial begin
    issue_valid_o = 1'b0;
    instr_o = 32'h0000_0000;
    src_a_o = 32'h0000_0000;
    src_b_o = 32'h0000_0000;
    src_d_o = 32'h0000_0000;
  end
  // called at a falling edge; held across the rising edge that takes it
  task automatic send(input logic [31:0] ins, a, b, d);
    issue_valid_o = 1'b1;
    instr_o = ins;
    src_a_o = a;
    src_b_o = b;
    src_d_o = d;
    @(negedge clk_i);
  endtask
  // idle operands flip so a stale value can never match by chance
  task automatic idle();
    issue_valid_o = 1'b0;
    instr_o = ~instr_o;
    src_a_o = ~src_a_o;
    src_b_o = ~src_b_o;
    src_d_o = ~src_d_o;
    @(negedge clk_i);
  endtask
endmodule

// ==== verif/tb.sv ====
// self-checking testbench for the general alu datapath
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv, wb_valid, wb_we, illegal;
  logic [31:0] ins, sa, sb, sd, wb_data;
  logic [4:0] wb_rd;
  int error_cnt = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  gac_core_model core (.clk_i(clk), .issue_valid_o(iv), .instr_o(ins),
    .src_a_o(sa), .src_b_o(sb), .src_d_o(sd));
  gac_alu DUT (.sys_clk_i(clk), .reset_i(rst), .issue_valid_i(iv),
    .instr_i(ins), .src_a_i(sa), .src_b_i(sb), .src_d_i(sd),
    .wb_valid_o(wb_valid), .wb_we_o(wb_we), .wb_rd_o(wb_rd),
    .wb_data_o(wb_data), .illegal_o(illegal));

  function automatic logic [31:0] reg_i(input logic [6:0] f, input
    logic [4:0] r2, rd);
    return {f, r2, 5'h03, 3'h3, rd, 7'h2B};
  endfunction
  function automatic logic [31:0] imm_i(input logic [1:0] f2, input
    logic [4:0] n, input logic [2:0] f3);
    return {f2, n, 5'h02, 5'h03, f3, 5'h07, 7'h5B};
  endfunction
  function automatic logic [31:0] norm(input logic [31:0] s, input
    logic [4:0] n, input logic rnd, uns);
    logic [31:0] t;
    t = s;
    if (rnd && n != 5'h00) t = t + (32'h1 << (n - 5'h01));
    if (uns) return t >> n;
    return $signed(t) >>> n;
  endfunction
  function automatic logic [31:0] exp_of(input logic [31:0] i, a, b, d);
    logic signed [31:0] x, y, lo, hi;
    logic [4:0] n;
    x = a;
    y = b;
    n = i[24:20];
    lo = (n == 5'h00) ? -32'sh1 : -(32'sh1 << (n - 5'h01));
    hi = (n == 5'h00) ? 32'sh0 : (32'sh1 << (n - 5'h01)) - 32'sh1;
    if (i[6:0] == 7'h5B)
      return norm(i[14:12] == 3'h3 ? a - b : a + b, i[29:25], i[31], i[30]);
    case (i[31:25])
      7'h28: return x < 0 ? -a : a;
      7'h29: return {31'h0, x <= y};
      7'h2A: return {31'h0, a <= b};
      7'h2B: return x < y ? a : b;
      7'h2C: return a < b ? a : b;
      7'h2D: return x < y ? b : a;
      7'h2E: return a < b ? b : a;
      7'h30: return {{16{a[15]}}, a[15:0]};
      7'h31: return {16'h0, a[15:0]};
      7'h32: return {{24{a[7]}}, a[7:0]};
      7'h33: return {24'h0, a[7:0]};
      7'h38: return x <= lo ? lo : x >= hi ? hi : x;
      7'h39: return x <= 0 ? 0 : x >= hi ? hi : x;
      7'h3A: return x <= -(y + 1) ? -(y + 1) : x >= y ? y : x;
      7'h3B: return x <= 0 ? 0 : x >= y ? y : x;
      default: return norm(i[27] ? d - a : d + a, b[4:0], i[26], i[25]);
    endcase
  endfunction

  task automatic run(input logic [31:0] i, a, b, d);
    logic [31:0] e;
    e = exp_of(i, a, b, d);
    core.send(i, a, b, d);
    `CHK(wb_valid, 1'b1)
    `CHK(wb_we, i[11:7] != 5'h00)
    `CHK(wb_rd, i[11:7])
    `CHK(wb_data, e)
  endtask

  logic [31:0] va[8] = '{32'hFFFF_FF9C, 32'hFFFF_FFF0, 32'h0000_000F,
    32'h0000_0010, 32'h0, 32'h8000_0000, 32'h7FFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] vb[8] = '{32'h5, 32'h0000_0010, 32'h0000_000F, 32'h1,
    32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFE3, 32'h0};
  logic [4:0] ns[4] = '{5'h00, 5'h01, 5'h05, 5'h1F};

  task automatic t_cmp_unary();
    logic [6:0] un[5] = '{7'h28, 7'h30, 7'h31, 7'h32, 7'h33};
    for (int f = 8'h29; f <= 8'h2E; f++)
      for (int k = 0; k < 8; k++)
        run(reg_i(7'(f), 5'h02, 5'h05), va[k], vb[k],
          32'h0);
    for (int f = 0; f < 5; f++)
      for (int k = 0; k < 8; k++)
        run(reg_i(un[f], 5'h00, 5'h06), va[k], vb[k],
          32'h0);
    $display("test compare and unary done");
  endtask

  task automatic t_clip();
    for (int f = 8'h38; f <= 8'h3B; f++)
      for (int j = 0; j < 4; j++)
        for (int k = 0; k < 8; k++)
          run(reg_i(7'(f), ns[j], 5'h08), va[k], vb[j + 2],
            32'h0);
    $display("test clip done");
  endtask

  task automatic t_norm();
    for (int f3 = 2; f3 <= 3; f3++)
      for (int f2 = 0; f2 < 4; f2++)
        for (int j = 0; j < 4; j++)
          for (int k = 5; k < 8; k++)
            run(imm_i(2'(f2), ns[j], 3'(f3)), va[k], vb[k - 5],
              32'h0);
    for (int f = 8'h40; f <= 8'h47; f++)
      for (int k = 0; k < 8; k++)
        run(reg_i(7'(f), 5'h09, 5'h0A), va[k], vb[k],
          va[7 - k]);
    $display("test normalise done");
  endtask

  task automatic t_refuse();
    core.send(reg_i(7'h28, 5'h01, 5'h04), 32'h5, 32'h0, 32'h0);
    `CHK(illegal, 1'b1)
    `CHK(wb_valid, 1'b0)
    core.send(reg_i(7'h2F, 5'h01, 5'h04), 32'h5, 32'h6, 32'h0);
    `CHK(illegal, 1'b0)
    `CHK(wb_valid, 1'b0)
    run(reg_i(7'h2B, 5'h01, 5'h00), 32'h1, 32'h2, 32'h0);
    core.idle();
    `CHK(wb_valid, 1'b0)
    $display("test refuse done");
  endtask

  // reset in mid-run: an issue seen with reset high is dropped
  task automatic t_reset();
    run(reg_i(7'h28, 5'h00, 5'h07), 32'hFFFF_FFFB, 32'h0, 32'h0);
    rst = 1'b1;
    core.send(reg_i(7'h28, 5'h00, 5'h09), 32'hFFFF_FFF7, 32'h0, 32'h0);
    `CHK(wb_valid, 1'b0)
    `CHK(wb_we, 1'b0)
    `CHK(wb_rd, 5'h00)
    `CHK(wb_data, 32'h0000_0000)
    `CHK(illegal, 1'b0)
    rst = 1'b0;
    run(reg_i(7'h28, 5'h00, 5'h09), 32'hFFFF_FFF7, 32'h0, 32'h0);
    $display("test reset done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #80000;
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_cmp_unary();
    t_clip();
    t_norm();
    t_refuse();
    t_reset();
    finish_test();
  end
endmodule
